// ===== design/shio_top.sv
// Purpose: Host-side serial settings and discrete input handling of a servo cylinder controller
// Assumes: Classic Wishbone slave, 32-bit data, inputs synchronous to clk_i
// Notes:   Link settings drive the line engine; inputs gate homing, moves and alarms
`timescale 1ns/1ps
`include "shio_defs.svh"

module shio_top
  import shio_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire shio_pins_s  pins_i,
  input  wire logic        home_complete_i,
  input  wire logic        alarm_event_i,
  input  wire logic        motion_busy_i,
  input  wire logic        pos_msg_valid_i,
  input  wire logic        pos_msg_bcast_i,
  output shio_cfg_s        serial_cfg_o,
  output logic      [13:0] bit_cycles_o,
  output logic             pos_msg_take_o,
  output logic             home_start_o,
  output logic             home_done_o,
  output logic             alarm_o,
  output logic             servo_on_o,
  output logic             manual_mode_o,
  output logic             move_req_o,
  output logic      [6:0]  move_point_o,
  output logic             decel_stop_o
);

  // Bit period per rate code, rounded down
  function automatic logic [13:0] speed_cycles(input logic [1:0] code);
    logic [13:0] c;
    c = 14'(`SHIO_CLK_HZ / `SHIO_BAUD_0);
    case (code)
      2'h1:    c = 14'(`SHIO_CLK_HZ / `SHIO_BAUD_1);
      2'h2:    c = 14'(`SHIO_CLK_HZ / `SHIO_BAUD_2);
      2'h3:    c = 14'(`SHIO_CLK_HZ / `SHIO_BAUD_3);
      default: c = 14'(`SHIO_CLK_HZ / `SHIO_BAUD_0);
    endcase
    return c;
  endfunction

  shio_pins_s  pins_c;        // Debounced pin levels
  shio_pins_s  prev_ff;       // Last debounced levels, for edges
  shio_home_e  home_st_ff;    // Home return progress
  shio_home_e  nxt_home_st;
  logic [31:0] nxt_rdata;     // Read mux
  logic [13:0] idx;           // Word index of the access
  logic [15:0] wval;          // Written half-word
  logic        wr_go;         // Write accepted this cycle
  logic        req;           // Fresh bus request
  logic        start_rise;
  logic        fclr_rise;
  logic        home_rise;
  logic        servo_act;     // Servo contact asks for excitation
  logic        lock_act;      // Interlock engaged
  logic        nxt_move;

  // All pin inputs cleaned first; points too, so a move never sees a half-set code
  shio_debounce #(
    .N       (`SHIO_NUM_IN),
    .RST_VAL (`SHIO_PIN_RST)
  ) u_deb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .raw_i   (pins_i),
    .clean_o (pins_c)
  );

  // Break contacts act when the contact opens, i.e. the level is low
  assign servo_act  = ~pins_c.servo_brk;
  assign lock_act   = ~pins_c.lock_brk;
  assign start_rise = pins_c.start & ~prev_ff.start;
  assign fclr_rise  = pins_c.fault_clear_input & ~prev_ff.fault_clear_input;
  assign home_rise  = pins_c.home_return_request & ~prev_ff.home_return_request;

  // Bus decode; 16-bit registers need both low lanes to be written
  assign idx   = wb_adr_i[15:2];
  assign wval  = wb_dat_i[15:0];
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go = ce_i & req & wb_we_i & (wb_sel_i[1:0] == 2'h3);

  // Edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff <= `SHIO_PIN_RST;
    end else if (ce_i) begin
      prev_ff <= pins_c;
    end
  end

  // Link settings; out-of-range codes are dropped so the line never runs odd
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_cfg_o.speed    <= `SHIO_RST_SPEED;
      serial_cfg_o.width7   <= 1'b0;
      serial_cfg_o.parity   <= `SHIO_RST_PARITY;
      serial_cfg_o.bcast_en <= 1'b0;
      serial_cfg_o.rtu      <= 1'b0;
    end else if (wr_go) begin
      case (idx)
        `SHIO_IDX_SPEED: begin
          if (wval <= `SHIO_MAX_SPEED) serial_cfg_o.speed <= wval[1:0];
        end
        `SHIO_IDX_WIDTH: begin
          if (wval <= `SHIO_MAX_WIDTH) serial_cfg_o.width7 <= wval[0];
        end
        `SHIO_IDX_PARITY: begin
          if (wval <= `SHIO_MAX_PARITY) serial_cfg_o.parity <= wval[1:0];
        end
        `SHIO_IDX_BCAST: begin
          if (wval <= `SHIO_MAX_BCAST) serial_cfg_o.bcast_en <= wval[0];
        end
        `SHIO_IDX_FRAME: begin
          if (wval <= `SHIO_MAX_FRAME) serial_cfg_o.rtu <= wval[0];
        end
        default: begin
          // Status and unmapped words ignore writes
        end
      endcase
    end
  end

  // Bit period follows the rate code one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cycles_o <= 14'(`SHIO_CLK_HZ / `SHIO_BAUD_0);
    end else if (ce_i) begin
      bit_cycles_o <= speed_cycles(serial_cfg_o.speed);
    end
  end

  // Group-addressed position messages pass only when enabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_msg_take_o <= 1'b0;
    end else if (ce_i) begin
      pos_msg_take_o <= pos_msg_valid_i & (~pos_msg_bcast_i | serial_cfg_o.bcast_en);
    end
  end

  // Read mux; reserved and unmapped words read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `SHIO_IDX_SPEED:  nxt_rdata[1:0] = serial_cfg_o.speed;
      `SHIO_IDX_WIDTH:  nxt_rdata[0]   = serial_cfg_o.width7;
      `SHIO_IDX_PARITY: nxt_rdata[1:0] = serial_cfg_o.parity;
      `SHIO_IDX_BCAST:  nxt_rdata[0]   = serial_cfg_o.bcast_en;
      `SHIO_IDX_FRAME:  nxt_rdata[0]   = serial_cfg_o.rtu;
      `SHIO_IDX_STATUS: nxt_rdata[6:0] = {motion_busy_i, decel_stop_o, manual_mode_o,
                                          servo_on_o, alarm_o, home_done_o,
                                          home_st_ff == HOME_RUN};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Single-wait-state answer; ack drops the cycle after it is given
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

  // Pending alarm; a new event in the clearing cycle wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_o <= 1'b0;
    end else if (ce_i) begin
      if (alarm_event_i) begin
        alarm_o <= 1'b1;
      end else if (fclr_rise) begin
        alarm_o <= 1'b0;
      end
    end
  end

  // Excitation ignores the interlock so the axis holds its place
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      servo_on_o <= 1'b0;
    end else if (ce_i) begin
      servo_on_o <= servo_act & ~alarm_o & ~alarm_event_i;
    end
  end

  // Interlock and manual mode are plain levels to the motion engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      decel_stop_o  <= 1'b0;
      manual_mode_o <= 1'b0;
    end else if (ce_i) begin
      decel_stop_o  <= lock_act;
      manual_mode_o <= pins_c.manual;
    end
  end

  // Home return sequence; coordinates are only trusted after it ends
  always_comb begin
    nxt_home_st = home_st_ff;
    unique case (home_st_ff)
      HOME_IDLE, HOME_DONE: begin
        if (home_rise && servo_on_o && !alarm_o) nxt_home_st = HOME_RUN;
      end
      HOME_RUN: begin
        if (alarm_o) begin
          nxt_home_st = HOME_IDLE;          // Aborted return leaves points untrusted
        end else if (home_complete_i) begin
          nxt_home_st = HOME_DONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      home_st_ff   <= HOME_IDLE;
      home_done_o  <= 1'b0;
      home_start_o <= 1'b0;
    end else if (ce_i) begin
      home_st_ff   <= nxt_home_st;
      home_done_o  <= (nxt_home_st == HOME_DONE);
      home_start_o <= (home_st_ff != HOME_RUN) && (nxt_home_st == HOME_RUN);
    end
  end

  // Start acts once per edge and only with a trusted, excited, unlocked, alarm-free, automatic axis
  assign nxt_move = start_rise & ~pins_c.manual & home_done_o & servo_on_o
                  & ~alarm_o & ~lock_act;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      move_req_o   <= 1'b0;
      move_point_o <= 7'h00;
    end else if (ce_i) begin
      move_req_o <= nxt_move;
      if (nxt_move) begin
        move_point_o <= pins_c.point;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_speed;
    ce_i |=> bit_cycles_o == speed_cycles($past(serial_cfg_o.speed));
  endproperty
  a_speed: assert property (p_speed) else $error("bit period wrong");

  property p_parity;
    wr_go && idx == `SHIO_IDX_PARITY && wval > `SHIO_MAX_PARITY
      |=> $stable(serial_cfg_o.parity);
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity taken");

  property p_bcast;
    ce_i && pos_msg_valid_i && pos_msg_bcast_i && !serial_cfg_o.bcast_en
      |=> !pos_msg_take_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("group msg passed");

  property p_frame;
    wr_go && idx == `SHIO_IDX_FRAME && wval <= `SHIO_MAX_FRAME
      |=> serial_cfg_o.rtu == $past(wval[0]);
  endproperty
  a_frame: assert property (p_frame) else $error("framing not set");

  property p_home;
    move_req_o |-> $past(home_done_o) && $past(ce_i);
  endproperty
  a_home: assert property (p_home) else $error("move before home");

  property p_clear;
    ce_i && fclr_rise && !alarm_event_i |=> !alarm_o;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared");

  property p_servo;
    ce_i && pins_c.servo_brk |=> !servo_on_o;
  endproperty
  a_servo: assert property (p_servo) else $error("servo on, contact shut");

  property p_lock;
    ce_i && lock_act && servo_act && !alarm_o && !alarm_event_i
      |=> decel_stop_o && servo_on_o;
  endproperty
  a_lock: assert property (p_lock) else $error("interlock misbehaves");

  property p_manual;
    move_req_o |-> !$past(pins_c.manual) && !manual_mode_o;
  endproperty
  a_manual: assert property (p_manual) else $error("move in manual");

  property p_once;
    ce_i && move_req_o |=> !move_req_o;
  endproperty
  a_once: assert property (p_once) else $error("start acted twice");

  c_move:  cover property (move_req_o);
  c_clear: cover property (alarm_o ##1 !alarm_o);
  c_lock:  cover property (decel_stop_o && motion_busy_i);
  c_bcast: cover property (pos_msg_take_o && serial_cfg_o.bcast_en);

endmodule

// ===== pkg/shio_defs.svh
// Purpose: Named offsets, codes, reset values and timing for the servo host block
// Assumes: 125 MHz core clock
// Notes:   Included by bare name; definitions only
`ifndef SHIO_DEFS_SVH
`define SHIO_DEFS_SVH

// Clock figures
`define SHIO_CLK_HZ       125000000
`define SHIO_CLK_NS       8

// Line rates selected by codes 0..3
`define SHIO_BAUD_0       9600
`define SHIO_BAUD_1       19200
`define SHIO_BAUD_2       38400
`define SHIO_BAUD_3       57600

// Register indices; byte address is four times the index
`define SHIO_IDX_SPEED    14'h0a00
`define SHIO_IDX_WIDTH    14'h0a01
`define SHIO_IDX_PARITY   14'h0a02
`define SHIO_IDX_BCAST    14'h0a03
`define SHIO_IDX_FRAME    14'h0a04
`define SHIO_IDX_STATUS   14'h0a05

// Largest legal code per register
`define SHIO_MAX_SPEED    16'h0003
`define SHIO_MAX_WIDTH    16'h0001
`define SHIO_MAX_PARITY   16'h0002
`define SHIO_MAX_BCAST    16'h0001
`define SHIO_MAX_FRAME    16'h0001

// Reset values of the link settings
`define SHIO_RST_SPEED    2'h0
`define SHIO_RST_PARITY   2'h0

// Debounce window: time in ns, count derived from the clock period
`define SHIO_DEB_NS       20000
`define SHIO_DEB_CYC      (`SHIO_DEB_NS / `SHIO_CLK_NS)
`define SHIO_DEB_W        12

// Discrete input count and reset level (break contacts rest high)
`define SHIO_NUM_IN       13
`define SHIO_PIN_RST      13'h0880

`endif

// ===== pkg/shio_pkg.sv
// Purpose: Types shared by the servo host block
// Assumes: Used together with shio_defs.svh
// Notes:   Packed structs carry grouped signals
package shio_pkg;

  // Serial link settings as seen by the line engine
  typedef struct packed {
    logic [1:0] speed;    // Line rate code
    logic       width7;   // 1: seven data bits
    logic [1:0] parity;   // 0 none, 1 even, 2 odd
    logic       bcast_en; // Accept group messages
    logic       rtu;      // 1: binary framing
  } shio_cfg_s;

  // Discrete host inputs, raw pin levels
  typedef struct packed {
    logic       home_return_request;
    logic       servo_brk;   // Break contact, active low
    logic       fault_clear_input;
    logic       start;
    logic       manual;
    logic       lock_brk;    // Break contact, active low
    logic [6:0] point;       // point_select_bit6..point_select_bit0
  } shio_pins_s;

  // Home return progress
  typedef enum logic [1:0] {HOME_IDLE, HOME_RUN, HOME_DONE} shio_home_e;

endpackage

// ===== design/shio_debounce.sv
// Purpose: Synchronise and debounce a group of discrete inputs
// Assumes: Bounce shorter than the window
// Notes:   One generate lane per input bit
`timescale 1ns/1ps
`include "shio_defs.svh"
module shio_debounce #(
  parameter int            N       = 1,
  parameter logic [N-1:0]  RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] clean_o
);

  localparam logic [`SHIO_DEB_W-1:0] DEB_LAST = `SHIO_DEB_W'(`SHIO_DEB_CYC - 1);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      logic                   meta_ff;  // First stage, read by sync_ff only
      logic                   sync_ff;  // Settled level
      logic [`SHIO_DEB_W-1:0] cnt_ff;   // Cycles the new level has held

      // Two-stage synchroniser against metastability
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff <= RST_VAL[g];
          sync_ff <= RST_VAL[g];
        end else if (ce_i) begin
          meta_ff <= raw_i[g];
          sync_ff <= meta_ff;
        end
      end

      // Level must hold a full window before it is believed
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_ff     <= '0;
          clean_o[g] <= RST_VAL[g];
        end else if (ce_i) begin
          if (sync_ff == clean_o[g]) begin
            cnt_ff <= '0;           // Bounce back restarts the window
          end else if (cnt_ff == DEB_LAST) begin
            cnt_ff     <= '0;
            clean_o[g] <= sync_ff;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

// ===== verification/shio_host_model.sv
// Purpose: Host controller model driving the discrete inputs of the servo host block
// Assumes: Pin wishes come from the bench; levels change only after a clock edge
// Notes:   Keeps the host-side ordering duties before handing levels to the pins
`timescale 1ns/1ps
module shio_host_model
  import shio_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       cause_i, // Alarm cause still present
  input  wire shio_pins_s want_i,  // Levels the bench asks for
  output shio_pins_s      pins_o   // Levels on the contacts
);
  // Pin levels move one edge after the wish, as a relay output would
  always_ff @(posedge clk_i) begin
    pins_o <= want_i;
    // Clear only once the cause is gone; a clear during the fault is pointless
    if (cause_i) begin
      pins_o.fault_clear_input <= 1'b0;
    end
    // No new start while the interlock still holds the axis
    if (!want_i.lock_brk) begin
      pins_o.start <= 1'b0;
    end
  end
endmodule

// ===== verification/shio_top_bench.sv
// Purpose: Self-checking bench for the servo host block
// Assumes: Classic Wishbone master; 2600 cycles cover sync and debounce
// Notes:   Pulse outputs are counted by a monitor, levels compared directly
`timescale 1ns/1ps
module shio_top_bench
  import shio_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ack, take, hstart, hdone, alm, son, man, mreq, dec;
  logic        hcomp, aev, busy, pval, pbc, cause, ce;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, q, dat_o;
  logic [13:0] bcyc;
  logic [6:0]  mpt, last_pt;
  shio_cfg_s   cfg, ecfg;
  shio_pins_s  pw, pins;
  int          n_errors, checks_done, n_move, n_home;
  int          mx[5] = '{3, 1, 2, 1, 1};          // Largest legal code per setting
  int          bc[4] = '{13020, 6510, 3255, 2170}; // Clocks per bit for codes 0..3

  shio_host_model u_host (.clk_i(clk), .cause_i(cause), .want_i(pw), .pins_o(pins));

  shio_top u_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pins_i(pins), .home_complete_i(hcomp), .alarm_event_i(aev), .motion_busy_i(busy),
    .pos_msg_valid_i(pval), .pos_msg_bcast_i(pbc), .serial_cfg_o(cfg), .bit_cycles_o(bcyc),
    .pos_msg_take_o(take), .home_start_o(hstart), .home_done_o(hdone), .alarm_o(alm),
    .servo_on_o(son), .manual_mode_o(man), .move_req_o(mreq), .move_point_o(mpt),
    .decel_stop_o(dec));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulses last one cycle, so count them rather than chase them
  always @(posedge clk) begin
    if (mreq === 1'b1) begin
      n_move++;
      last_pt = mpt;
    end
    if (hstart === 1'b1) begin
      n_home++;
    end
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; waits for ack, releases, then one idle cycle
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [15:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0000_0bad, 32'h0); // Bus hang counts as a mismatch
      end_of_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Let the pins pass synchroniser and debounce window
  task automatic settle();
    repeat (2600) @(posedge clk);
  endtask

  // One position message and whether it must be taken
  task automatic msg(input logic grp, input logic exp);
    pval <= 1'b1;
    pbc  <= grp;
    @(posedge clk);
    pval <= 1'b0;
    @(posedge clk);
    chk(take, exp);
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 24k cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {rst, cyc, stb, we, hcomp, aev, busy, pval, pbc, cause} = '0;
    {adr, sel, dat, ecfg, n_errors, checks_done, n_move, n_home} = '0;
    rst = 1'b1;
    ce = 1'b1;
    pw = '0;
    pw.servo_brk = 1'b1; // Break contacts rest closed
    pw.lock_brk = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(bcyc, 32'd13020);
    chk(cfg, 32'h0);
    // Every code, then one past the largest, which must be ignored
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c <= mx[r] + 1; c++) begin
        xfer(1'b1, 14'h0a00 + r[13:0], c[15:0], 4'hf);
        if (c <= mx[r]) begin
          case (r)
            0: ecfg.speed = c[1:0];
            1: ecfg.width7 = c[0];
            2: ecfg.parity = c[1:0];
            3: ecfg.bcast_en = c[0];
            default: ecfg.rtu = c[0];
          endcase
        end
        xfer(1'b0, 14'h0a00 + r[13:0], 16'h0, 4'hf);
        chk(q, (c > mx[r]) ? mx[r] : c);
        chk(cfg, ecfg);
        chk(bcyc, bc[ecfg.speed]);
      end
    end
    xfer(1'b1, 14'h0a00, 16'h0001, 4'h1); // Partial lanes, no effect
    xfer(1'b0, 14'h0a00, 16'h0, 4'hf);
    chk(q, 32'h3);
    xfer(1'b0, 14'h0a06, 16'h0, 4'hf);
    chk(q, 32'h0);
    msg(1'b1, 1'b1);
    xfer(1'b1, 14'h0a03, 16'h0, 4'hf);
    msg(1'b1, 1'b0);
    msg(1'b0, 1'b1);
    xfer(1'b1, 14'h0a04, 16'h0, 4'hf); // Cascade needs ASCII
    chk(cfg.rtu, 1'b0);
    // Servo on, then start before any home return
    pw.servo_brk <= 1'b0;
    settle();
    chk(son, 1'b1);
    pw.start <= 1'b1;
    pw.point <= 7'd41;
    settle();
    chk(n_move, 0);
    pw.start <= 1'b0;
    pw.home_return_request <= 1'b1;
    settle();
    chk(n_home, 1);
    hcomp <= 1'b1;
    @(posedge clk);
    hcomp <= 1'b0;
    repeat (2) @(posedge clk);
    chk(hdone, 1'b1);
    pw.home_return_request <= 1'b0;
    pw.start <= 1'b1;
    settle();
    chk(n_move, 1);
    chk(last_pt, 7'd41);
    pw.start <= 1'b0;
    pw.manual <= 1'b1;
    settle();
    chk(man, 1'b1);
    pw.start <= 1'b1;
    settle();
    chk(n_move, 1);
    pw <= '0;
    busy <= 1'b1;
    settle();
    chk(dec, 1'b1);
    chk(son, 1'b1);
    xfer(1'b0, 14'h0a05, 16'h0, 4'hf);
    chk(q, 32'h6a);
    busy <= 1'b0;
    pw.lock_brk <= 1'b1; // Interlock released first
    settle();
    chk(dec, 1'b0);
    // A frozen core must miss an event that comes while enable is low
    ce  <= 1'b0;
    aev <= 1'b1;
    @(posedge clk);
    aev <= 1'b0;
    ce  <= 1'b1;
    @(posedge clk);
    chk(alm, 1'b0);
    aev <= 1'b1;
    cause <= 1'b1;
    @(posedge clk);
    aev <= 1'b0;
    cause <= 1'b0; // Cause removed before the clear
    repeat (3) @(posedge clk);
    chk(alm, 1'b1);
    chk(son, 1'b0);
    pw.fault_clear_input <= 1'b1;
    settle();
    chk(alm, 1'b0);
    chk(son, 1'b1);
    end_of_test();
  end
endmodule
